/* File: rtl/psr_pkg.sv */
package psr_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_DIFF_HIGH = 8'h19;
  localparam logic [7:0] ADDR_DIFF_LOW = 8'h1A;
  localparam logic [7:0] ADDR_OFFSET_HIGH = 8'h1B;
  localparam logic [7:0] ADDR_OFFSET_LOW = 8'h1C;
  localparam logic [7:0] ADDR_SENS_FREQ = 8'h1D;
  localparam logic [7:0] ADDR_ROUTE = 8'h1E;
  localparam logic [7:0] ADDR_BOOST = 8'h1F;
  localparam logic [7:0] ADDR_TRIM = 8'h20;
  localparam logic [7:0] ADDR_SPARE = 8'h21;
  localparam logic [7:0] ADDR_INT_MASK = 8'h22;

  // field widths and positions
  localparam int DIFF_W = 13;
  localparam int DIFF_HIGH_W = 5;
  localparam int OFFSET_W = 16;
  localparam int GAIN_LSB = 4;
  localparam int FREQ_LSB = 1;
  localparam int SENSOR_LSB = 4;
  localparam int SHIELD_LSB = 0;
  localparam int BOOST_LSB = 3;
  localparam int BOOST_LOW_LSB = 0;

  // reset values
  localparam logic [2:0] GAIN_RESET = 3'h0;
  localparam logic [2:0] FREQ_RESET = 3'h0;
  localparam logic [3:0] ROUTE_RESET = 4'h0;
  localparam logic [2:0] BOOST_RESET = 3'h0;
  localparam logic [7:0] TRIM_RESET = 8'h01;
  localparam logic [7:0] MASK_RESET = 8'h08;

  // frequency codes
  localparam logic [2:0] FREQ_64K = 3'h2;
  localparam logic [2:0] FREQ_90K = 3'h3;
  localparam logic [2:0] FREQ_112K = 3'h4;
  localparam logic [2:0] FREQ_150K = 3'h5;

  // sensor route codes
  localparam logic [3:0] SENSOR_NONE = 4'h0;
  localparam logic [3:0] SENSOR_WIPER = 4'h1;
  localparam logic [3:0] SENSOR_AUX2 = 4'h2;
  localparam logic [3:0] SENSOR_X = 4'h8;
  localparam logic [3:0] SENSOR_Y = 4'h9;

  // shield route codes
  localparam logic [3:0] SHIELD_NONE = 4'h0;
  localparam logic [3:0] SHIELD_AUX3 = 4'h3;
  localparam logic [3:0] SHIELD_X = 4'h8;
  localparam logic [3:0] SHIELD_Y = 4'h9;

  // boost codes
  localparam logic [2:0] BOOST_ON = 3'h4;
  localparam logic [2:0] BOOST_OFF = 3'h6;

  // interrupt mask bit positions
  localparam int INT_MOTOR_SHORT = 7;
  localparam int INT_OBJECT_NEAR = 6;
  localparam int INT_AWAY_OR_DONE = 5;
  localparam int INT_COMP_DONE = 4;
  localparam int INT_TOUCH_DOWN_OR_DONE = 3;
  localparam int INT_TOUCH_UP = 2;
  localparam int INT_THERMAL_WARNING = 1;
  localparam int INT_THERMAL_ALARM = 0;

  // instantaneous status from the device core
  typedef struct packed {
    logic motor_short;
    logic object_near_state;
    logic comp_pending;
    logic conversion_running_flag;
    logic touch_state_flag;
  } psr_status_t;

  // proximity results from the front end
  typedef struct packed {
    logic sense_conversion_complete;
    logic [DIFF_W-1:0] differential;
    logic [OFFSET_W-1:0] comp_offset;
  } psr_result_t;

  // register access port from the serial interface
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } psr_reg_req_t;

  // decoded configuration for the analog front end
  typedef struct packed {
    logic [2:0] sense_gain_level;
    logic [2:0] sense_operating_frequency;
    logic [3:0] sensor_pin_route;
    logic [3:0] shield_pin_route;
    logic [2:0] high_gain_select;
    logic [2:0] boost_low_bits;
    logic [7:0] trim;
    logic high_gain_on;
    logic code_reserved;
  } psr_cfg_t;

  // whole state of the bank
  typedef struct packed {
    logic [2:0] gain;
    logic [2:0] freq;
    logic [3:0] sensor;
    logic [3:0] shield;
    logic [2:0] boost;
    logic [2:0] boost_low;
    logic [7:0] trim;
    logic [7:0] mask;
    logic [DIFF_W-1:0] diff;
    logic [OFFSET_W-1:0] offset;
    psr_status_t prev;
    logic conv_was_prox;
    logic [7:0] events;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
  } psr_state_t;

endpackage

/* File: rtl/psr_regs.sv */
// Operation
// RULE1: differential is signed, five high, eight low bits
// RULE2: host only reads results after conversion done
// RULE3: sixteen-bit offset, high byte then low byte
// RULE4: gain field bits 6:4, resets zero
// RULE5: frequency field bits 3:1, codes 010..101
// RULE6: sensor route bits 7:4, other codes reserved
// RULE7: shield route bits 3:0, other codes reserved
// RULE8: boost bits 5:3, 100 on, 110 off
// RULE9: host writes 0x81 to trim register
// RULE10: mask holds one enable per source
// RULE11: touch enable bit 3 resets to one
// RULE12: bit 5 source chosen by select bit
// RULE13: touch source: pen rise or conversion end
// RULE14: bit 5: near fall or conversion end
// RULE15: masked source never raises interrupt request
module psr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register access from the serial interface
  input wire psr_pkg::psr_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // proximity results and core status
  input wire psr_pkg::psr_result_t result,
  input wire psr_pkg::psr_status_t status,
  input wire logic conversion_is_prox,
  input wire logic touch_detect_mode,
  input wire logic away_or_done_select,
  input wire logic thermal_warning_event,
  input wire logic thermal_alarm_event,
  // front end configuration
  output psr_pkg::psr_cfg_t cfg,
  // interrupt sources
  output logic [7:0] int_events,
  output logic irq_request
);

  psr_pkg::psr_state_t s_q;
  psr_pkg::psr_state_t s_d;
  logic [7:0] raw_events;
  logic conv_fall;
  logic [7:0] read_mux;
  logic [7:0] gated_events;

  // elaboration checks: captured results must fill their register pairs
  if (psr_pkg::DIFF_W != psr_pkg::DIFF_HIGH_W + 8) begin
    $error("differential width does not match its two registers");
  end

  if (psr_pkg::DIFF_HIGH_W > 8) begin
    $error("differential high field wider than a byte");
  end

  if (psr_pkg::OFFSET_W != 16) begin
    $error("offset must fill exactly two bytes");
  end

  // elaboration checks: configuration fields inside their byte, no overlap
  if (psr_pkg::GAIN_LSB + 3 > 8) begin
    $error("gain field leaves its byte");
  end

  if (psr_pkg::FREQ_LSB + 3 > psr_pkg::GAIN_LSB) begin
    $error("frequency field overlaps the gain field");
  end

  if (psr_pkg::SENSOR_LSB + 4 > 8) begin
    $error("sensor route field leaves its byte");
  end

  if (psr_pkg::SHIELD_LSB + 4 > psr_pkg::SENSOR_LSB) begin
    $error("shield route field overlaps the sensor route field");
  end

  if (psr_pkg::BOOST_LSB + 3 > 8) begin
    $error("boost field leaves its byte");
  end

  if (psr_pkg::BOOST_LOW_LSB + 3 > psr_pkg::BOOST_LSB) begin
    $error("low boost bits overlap the boost field");
  end

  // elaboration checks: codes the decoders tell apart must differ
  if (psr_pkg::BOOST_ON == psr_pkg::BOOST_OFF) begin
    $error("boost on and off codes coincide");
  end

  if (psr_pkg::FREQ_64K == psr_pkg::FREQ_90K || psr_pkg::FREQ_90K == psr_pkg::FREQ_112K ||
      psr_pkg::FREQ_112K == psr_pkg::FREQ_150K || psr_pkg::FREQ_64K == psr_pkg::FREQ_150K) begin
    $error("frequency codes coincide");
  end

  if (psr_pkg::SENSOR_X == psr_pkg::SENSOR_Y || psr_pkg::SHIELD_X == psr_pkg::SHIELD_Y ||
      psr_pkg::SENSOR_NONE == psr_pkg::SENSOR_WIPER || psr_pkg::SHIELD_NONE == psr_pkg::SHIELD_AUX3) begin
    $error("route codes coincide");
  end

  // elaboration checks: reset values the host relies on
  if (psr_pkg::GAIN_RESET != 3'h0) begin
    $error("gain must reset to its least sensitive code");
  end

  if (psr_pkg::FREQ_RESET != 3'h0 || psr_pkg::ROUTE_RESET != 4'h0 || psr_pkg::BOOST_RESET != 3'h0) begin
    $error("configuration fields must reset to zero");
  end

  if (psr_pkg::TRIM_RESET != 8'h01) begin
    $error("trim register must reset to one");
  end

  // elaboration checks: the read decoder needs ten consecutive addresses
  if (psr_pkg::ADDR_INT_MASK != psr_pkg::ADDR_DIFF_HIGH + 8'h09) begin
    $error("register map is not ten consecutive bytes");
  end

  // elaboration checks: one mask bit per source, only the touch enable set at reset
  if (((8'h01 << psr_pkg::INT_MOTOR_SHORT) | (8'h01 << psr_pkg::INT_OBJECT_NEAR) |
      (8'h01 << psr_pkg::INT_AWAY_OR_DONE) | (8'h01 << psr_pkg::INT_COMP_DONE) |
      (8'h01 << psr_pkg::INT_TOUCH_DOWN_OR_DONE) | (8'h01 << psr_pkg::INT_TOUCH_UP) |
      (8'h01 << psr_pkg::INT_THERMAL_WARNING) | (8'h01 << psr_pkg::INT_THERMAL_ALARM)) != 8'hFF) begin
    $error("interrupt sources do not map onto distinct mask bits");
  end
  if (psr_pkg::MASK_RESET != (8'h01 << psr_pkg::INT_TOUCH_DOWN_OR_DONE)) begin
    $error("only the touch enable may be set after reset");
  end

  // per-source gating by the registered mask
  for (genvar g = 0; g < 8; g++) begin : g_gate
    assign gated_events[g] = raw_events[g] & s_q.mask[g]; // RULE15
  end

  // edge detection of the core status
  always_comb begin
    conv_fall = s_q.prev.conversion_running_flag & ~status.conversion_running_flag;
    raw_events = 8'h00;
    raw_events[psr_pkg::INT_MOTOR_SHORT] = status.motor_short & ~s_q.prev.motor_short;
    raw_events[psr_pkg::INT_OBJECT_NEAR] = status.object_near_state & ~s_q.prev.object_near_state;
    if (away_or_done_select) begin
      raw_events[psr_pkg::INT_AWAY_OR_DONE] = conv_fall & s_q.conv_was_prox; // RULE14
    end else begin
      raw_events[psr_pkg::INT_AWAY_OR_DONE] = s_q.prev.object_near_state & ~status.object_near_state; // RULE14
    end
    raw_events[psr_pkg::INT_COMP_DONE] = s_q.prev.comp_pending & ~status.comp_pending;
    if (touch_detect_mode) begin
      raw_events[psr_pkg::INT_TOUCH_DOWN_OR_DONE] = status.touch_state_flag & ~s_q.prev.touch_state_flag; // RULE13
    end else begin
      raw_events[psr_pkg::INT_TOUCH_DOWN_OR_DONE] = conv_fall & ~s_q.conv_was_prox; // RULE13
    end
    raw_events[psr_pkg::INT_TOUCH_UP] = s_q.prev.touch_state_flag & ~status.touch_state_flag;
    raw_events[psr_pkg::INT_THERMAL_WARNING] = thermal_warning_event;
    raw_events[psr_pkg::INT_THERMAL_ALARM] = thermal_alarm_event;
  end

  // read data selection, reserved bits read zero
  always_comb begin
    read_mux = 8'h00;
    case (reg_req.addr)
      psr_pkg::ADDR_DIFF_HIGH: begin
        read_mux[psr_pkg::DIFF_HIGH_W-1:0] = s_q.diff[psr_pkg::DIFF_W-1:8]; // RULE1
      end
      psr_pkg::ADDR_DIFF_LOW: begin
        read_mux = s_q.diff[7:0]; // RULE1
      end
      psr_pkg::ADDR_OFFSET_HIGH: begin
        read_mux = s_q.offset[15:8]; // RULE3
      end
      psr_pkg::ADDR_OFFSET_LOW: begin
        read_mux = s_q.offset[7:0]; // RULE3
      end
      psr_pkg::ADDR_SENS_FREQ: begin
        read_mux[psr_pkg::GAIN_LSB +: 3] = s_q.gain;
        read_mux[psr_pkg::FREQ_LSB +: 3] = s_q.freq;
      end
      psr_pkg::ADDR_ROUTE: begin
        read_mux[psr_pkg::SENSOR_LSB +: 4] = s_q.sensor;
        read_mux[psr_pkg::SHIELD_LSB +: 4] = s_q.shield;
      end
      psr_pkg::ADDR_BOOST: begin
        read_mux[psr_pkg::BOOST_LSB +: 3] = s_q.boost;
        read_mux[psr_pkg::BOOST_LOW_LSB +: 3] = s_q.boost_low;
      end
      psr_pkg::ADDR_TRIM: begin
        read_mux = s_q.trim;
      end
      psr_pkg::ADDR_INT_MASK: begin
        read_mux = s_q.mask;
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  // next state of the whole bank
  always_comb begin
    s_d = s_q;
    s_d.prev = status;
    // remember the kind of the running conversion
    if (status.conversion_running_flag) begin
      s_d.conv_was_prox = conversion_is_prox;
    end
    // results captured only on conversion complete; host writes never reach them
    if (result.sense_conversion_complete) begin
      s_d.diff = result.differential; // RULE1
      s_d.offset = result.comp_offset; // RULE3
    end
    // writes to configuration and mask
    if (reg_req.wr) begin
      case (reg_req.addr)
        psr_pkg::ADDR_SENS_FREQ: begin
          s_d.gain = reg_req.wdata[psr_pkg::GAIN_LSB +: 3]; // RULE4
          s_d.freq = reg_req.wdata[psr_pkg::FREQ_LSB +: 3]; // RULE5
        end
        psr_pkg::ADDR_ROUTE: begin
          s_d.sensor = reg_req.wdata[psr_pkg::SENSOR_LSB +: 4]; // RULE6
          s_d.shield = reg_req.wdata[psr_pkg::SHIELD_LSB +: 4]; // RULE7
        end
        psr_pkg::ADDR_BOOST: begin
          s_d.boost = reg_req.wdata[psr_pkg::BOOST_LSB +: 3]; // RULE8
          s_d.boost_low = reg_req.wdata[psr_pkg::BOOST_LOW_LSB +: 3]; // RULE8
        end
        psr_pkg::ADDR_TRIM: begin
          s_d.trim = reg_req.wdata; // RULE9
        end
        psr_pkg::ADDR_INT_MASK: begin
          s_d.mask = reg_req.wdata; // RULE10
        end
        default: begin
          s_d.mask = s_q.mask;
        end
      endcase
    end
    // request from sources gated by the current mask; events kept ungated
    s_d.events = raw_events;
    s_d.irq = |gated_events; // RULE15 RULE12
    // registered read answer
    s_d.rvalid = reg_req.rd;
    if (reg_req.rd) begin
      s_d.rdata = read_mux;
    end
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // configuration and mask
      s_q.gain <= psr_pkg::GAIN_RESET; // RULE4
      s_q.freq <= psr_pkg::FREQ_RESET;
      s_q.sensor <= psr_pkg::ROUTE_RESET;
      s_q.shield <= psr_pkg::ROUTE_RESET;
      s_q.boost <= psr_pkg::BOOST_RESET;
      s_q.boost_low <= psr_pkg::BOOST_RESET;
      s_q.trim <= psr_pkg::TRIM_RESET;
      s_q.mask <= psr_pkg::MASK_RESET; // RULE11
      // captured results
      s_q.diff <= '0;
      s_q.offset <= '0;
      // edge history and registered outputs
      s_q.prev <= '0;
      s_q.conv_was_prox <= 1'b0;
      s_q.events <= 8'h00;
      s_q.rdata <= 8'h00;
      s_q.rvalid <= 1'b0;
      s_q.irq <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // configuration outputs and reserved-code flag
  always_comb begin
    cfg.sense_gain_level = s_q.gain;
    cfg.sense_operating_frequency = s_q.freq;
    cfg.sensor_pin_route = s_q.sensor;
    cfg.shield_pin_route = s_q.shield;
    cfg.high_gain_select = s_q.boost;
    cfg.boost_low_bits = s_q.boost_low;
    cfg.trim = s_q.trim;
    cfg.high_gain_on = (s_q.boost == psr_pkg::BOOST_ON); // RULE8
    cfg.code_reserved = 1'b0;
    if (!(s_q.freq inside {psr_pkg::FREQ_64K, psr_pkg::FREQ_90K, psr_pkg::FREQ_112K,
        psr_pkg::FREQ_150K})) begin
      cfg.code_reserved = 1'b1; // RULE5
    end
    if (!(s_q.sensor inside {psr_pkg::SENSOR_NONE, psr_pkg::SENSOR_WIPER, psr_pkg::SENSOR_AUX2,
        psr_pkg::SENSOR_X, psr_pkg::SENSOR_Y})) begin
      cfg.code_reserved = 1'b1; // RULE6
    end
    if (!(s_q.shield inside {psr_pkg::SHIELD_NONE, psr_pkg::SHIELD_AUX3, psr_pkg::SHIELD_X,
        psr_pkg::SHIELD_Y})) begin
      cfg.code_reserved = 1'b1; // RULE7
    end
    if (!(s_q.boost inside {psr_pkg::BOOST_ON, psr_pkg::BOOST_OFF})) begin
      cfg.code_reserved = 1'b1; // RULE8
    end
  end

  // registered outputs
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign int_events = s_q.events;
  assign irq_request = s_q.irq;

endmodule

/* File: test/psr_chk.sv */
module psr_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire psr_pkg::psr_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // core side
  input wire psr_pkg::psr_result_t result,
  input wire psr_pkg::psr_status_t status,
  input wire logic conversion_is_prox,
  input wire logic touch_detect_mode,
  input wire logic away_or_done_select,
  input wire logic thermal_warning_event,
  input wire logic thermal_alarm_event,
  // outputs
  input wire psr_pkg::psr_cfg_t cfg,
  input wire logic [7:0] int_events,
  input wire logic irq_request
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [28:0] res_q;
  logic [7:0] mask_q;
  // shadow of captured results and of the mask
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      res_q <= '0;
      mask_q <= psr_pkg::MASK_RESET;
    end else begin
      if (result.sense_conversion_complete) res_q <= result[28:0];
      if (reg_req.wr && reg_req.addr == psr_pkg::ADDR_INT_MASK) mask_q <= reg_req.wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  diff_low_a: assert property (reg_req.rd && reg_req.addr == 8'h1A |=> reg_rdata == $past(res_q[23:16]))
    else $error("differential low byte wrong");
  offset_low_a: assert property (reg_req.rd && reg_req.addr == 8'h1C |=> reg_rdata == $past(res_q[7:0]))
    else $error("offset low byte wrong");
  gain_freq_a: assert property (reg_req.wr && reg_req.addr == 8'h1D |=>
    {cfg.sense_gain_level, cfg.sense_operating_frequency} == $past(reg_req.wdata[6:1]))
    else $error("gain or frequency not taken");
  route_write_a: assert property (reg_req.wr && reg_req.addr == 8'h1E |=>
    {cfg.sensor_pin_route, cfg.shield_pin_route} == $past(reg_req.wdata))
    else $error("routing not taken");
  boost_write_a: assert property (reg_req.wr && reg_req.addr == 8'h1F |=>
    cfg.high_gain_select == $past(reg_req.wdata[5:3]) && cfg.high_gain_on == ($past(reg_req.wdata[5:3]) == 3'h4))
    else $error("boost not taken");
  mask_gate_a: assert property (irq_request == |(int_events & $past(mask_q)))
    else $error("request not gated by mask");
  touch_down_a: assert property (touch_detect_mode && $rose(status.touch_state_flag) |=> int_events[3])
    else $error("touch down event missing");
  object_away_a: assert property ($past(reset_n) && !away_or_done_select &&
    $fell(status.object_near_state) |=> int_events[5])
    else $error("object away event missing");
endmodule

/* File: test/psr_host.sv */
module psr_host (
  // clock
  input wire logic clk,
  // register port
  output psr_pkg::psr_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial reg_req = '0;
  // one write strobe, data scrambled after release
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk) #10;
    reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: w};
    @(posedge clk) #10;
    reg_req.wr = 1'b0;
    reg_req.wdata = ~w;
  endtask
  // one read strobe, data taken while valid stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #10;
    reg_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk) #10;
    reg_req.rd = 1'b0;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule

/* File: test/psr_regs_tb.sv */
module psr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  psr_pkg::psr_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  psr_pkg::psr_result_t result = '0;
  psr_pkg::psr_status_t status = '0;
  logic conversion_is_prox = 1'b0;
  logic touch_detect_mode = 1'b0;
  logic away_or_done_select = 1'b0;
  logic thermal_warning_event = 1'b0;
  logic thermal_alarm_event = 1'b0;
  psr_pkg::psr_cfg_t cfg;
  logic [7:0] int_events;
  logic irq_request;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] d;
  logic [7:0] rst_v [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h08};
  logic [7:0] rte [5] = '{8'h00, 8'h13, 8'h28, 8'h89, 8'h98};
  logic [7:0] res_v [4] = '{8'h1A, 8'h5C, 8'hBE, 8'hEF};
  psr_regs psr_regs_inst (.clk, .reset_n, .reg_req, .reg_rdata, .reg_rvalid, .result, .status,
    .conversion_is_prox, .touch_detect_mode, .away_or_done_select, .thermal_warning_event,
    .thermal_alarm_event, .cfg, .int_events, .irq_request);
  psr_host psr_host_inst (.clk, .reg_req, .reg_rdata, .reg_rvalid);
  // clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      complete_run();
    end
  end
  // verdict and end of run
  task automatic complete_run();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // register read, write then read back
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    psr_host_inst.rd(a, d);
    chk(d, exp);
  endtask
  task automatic wrchk(input logic [7:0] a, input logic [7:0] w, input logic [7:0] exp);
    psr_host_inst.wr(a, w);
    rchk(a, exp);
  endtask
  // a single source event one cycle after its cause
  task automatic ev(input int i, input logic irq);
    @(posedge clk) #10;
    chk(int_events, 8'h01 << i);
    chk({7'h00, irq_request}, {7'h00, irq});
    thermal_warning_event = 1'b0;
    thermal_alarm_event = 1'b0;
  endtask
  task automatic conv(input logic p, input int i);
    status.conversion_running_flag = 1'b1;
    conversion_is_prox = p;
    @(posedge clk) #10;
    status.conversion_running_flag = 1'b0;
    ev(i, 1'b1);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    #10 reset_n = 1'b1;
    foreach (rst_v[k]) rchk(8'h19 + 8'(k), rst_v[k]);
    rchk(8'h40, 8'h00);
    wrchk(8'h1F, 8'h34, 8'h34);
    for (int c = 2; c < 6; c++) wrchk(8'h1D, 8'(c * 18), 8'(c * 18));
    wrchk(8'h1D, 8'hFF, 8'h7E);
    chk({7'h00, cfg.code_reserved}, 8'h01);
    wrchk(8'h1D, 8'h5A, 8'h5A);
    for (int i = 0; i < 5; i++) begin
      wrchk(8'h1E, rte[i], rte[i]);
      chk({7'h00, cfg.code_reserved}, 8'h00);
    end
    wrchk(8'h1E, 8'h55, 8'h55);
    chk({7'h00, cfg.code_reserved}, 8'h01);
    wrchk(8'h1F, 8'hE4, 8'h24);
    chk({5'h00, cfg.boost_low_bits}, 8'h04);
    chk({7'h00, cfg.high_gain_on}, 8'h01);
    wrchk(8'h1F, 8'h34, 8'h34);
    chk({7'h00, cfg.high_gain_on}, 8'h00);
    wrchk(8'h20, 8'h81, 8'h81);
    chk(cfg.trim, 8'h81);
    for (int a = 8'h19; a < 8'h1D; a++) rchk(8'(a), 8'h00);
    wrchk(8'h21, 8'hA5, 8'h00);
    // capture one negative result, then change the inputs
    result = '{1'b1, 13'h1A5C, 16'hBEEF};
    @(posedge clk) #10;
    result = '0;
    foreach (res_v[k]) rchk(8'h19 + 8'(k), res_v[k]);
    // each source but the thermal alarm alone with all enables on
    psr_host_inst.wr(8'h22, 8'hFF);
    status.motor_short = 1'b1;
    ev(7, 1'b1);
    status.object_near_state = 1'b1;
    ev(6, 1'b1);
    status.object_near_state = 1'b0;
    ev(5, 1'b1);
    status.comp_pending = 1'b1;
    @(posedge clk) #10;
    status.comp_pending = 1'b0;
    ev(4, 1'b1);
    touch_detect_mode = 1'b1;
    status.touch_state_flag = 1'b1;
    ev(3, 1'b1);
    status.touch_state_flag = 1'b0;
    ev(2, 1'b1);
    touch_detect_mode = 1'b0;
    conv(1'b0, 3);
    away_or_done_select = 1'b1;
    conv(1'b1, 5);
    thermal_warning_event = 1'b1;
    ev(1, 1'b1);
    // masked source shows its event without a request
    psr_host_inst.wr(8'h22, 8'hFE);
    thermal_alarm_event = 1'b1;
    ev(0, 1'b0);
    psr_host_inst.wr(8'h22, 8'h01);
    thermal_alarm_event = 1'b1;
    ev(0, 1'b1);
    complete_run();
  end
endmodule
bind psr_regs psr_chk psr_chk_inst (.clk, .reset_n, .reg_req, .reg_rdata, .reg_rvalid, .result, .status,
  .conversion_is_prox, .touch_detect_mode, .away_or_done_select, .thermal_warning_event,
  .thermal_alarm_event, .cfg, .int_events, .irq_request);
